//--- bench/adc_core_offset_gain_trim_bank_bench.sv
// self-checking bench of the offset and fine-gain trim bank
// assumes the design's own assertions stand in its files; bench plays bus master and fuse store
`timescale 1ns/10ps
`include "trim_bank_consts.svh"

module adc_core_offset_gain_trim_bank_bench;
    import trim_bank_pkg::*;

    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [`ADDR_W-1:0] addr = '0;
    logic [`DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [`DATA_W-1:0] rdata;
    logic fuse_rd_en;
    logic [`FUSE_IDX_W-1:0] fuse_rd_addr;
    logic [`OFS_W-1:0] fuse_rd_data = '0;
    logic fg_cal_en = 1'b0;
    logic clk_phase90 = 1'b0;
    logic sel_analog_input_b = 1'b0;
    logic [`TRIM_FIELD_MSB:0] core_a_offset;
    logic [`TRIM_FIELD_MSB:0] core_b_offset;
    logic [`GAIN_FIELD_MSB:0] fine_gain_bank_zero;
    logic [`GAIN_FIELD_MSB:0] fine_gain_bank_one;
    logic [`GAIN_FIELD_MSB:0] fine_gain_bank_four;
    logic trim_ready;
    int err_total = 0;
    int total_checks = 0;
    logic [15:0] ofs_m [6];
    logic [7:0] gain_m [3];
    logic [11:0] oa [6] = '{`OFFSET_TRIM_A_PHASE0_IN_A, `OFFSET_TRIM_A_PHASE0_IN_B,
        `OFFSET_TRIM_A_PHASE90_IN_A, `OFFSET_TRIM_A_PHASE90_IN_B,
        `OFFSET_TRIM_B_PHASE0_IN_A, `OFFSET_TRIM_B_PHASE0_IN_B};
    logic [11:0] ga [3] = '{`OFFSET_FINE_GAIN_BANK_ZERO, `OFFSET_FINE_GAIN_BANK_ONE,
        `OFFSET_FINE_GAIN_BANK_FOUR};
    logic [4:0] gout [3];

    always #50 core_clk = ~core_clk;

    adc_core_offset_gain_trim_bank i_adc_core_offset_gain_trim_bank (
        .core_clk(core_clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .fuse_rd_en(fuse_rd_en),
        .fuse_rd_addr(fuse_rd_addr), .fuse_rd_data(fuse_rd_data),
        .fg_cal_en(fg_cal_en), .clk_phase90(clk_phase90),
        .sel_analog_input_b(sel_analog_input_b), .core_a_offset(core_a_offset),
        .core_b_offset(core_b_offset), .fine_gain_bank_zero(fine_gain_bank_zero),
        .fine_gain_bank_one(fine_gain_bank_one), .fine_gain_bank_four(fine_gain_bank_four),
        .trim_ready(trim_ready)
    );

    assign gout = '{fine_gain_bank_zero, fine_gain_bank_one, fine_gain_bank_four};

    // distinct bytes per word so a misrouted fuse word shows up
    function automatic logic [15:0] fw(input int i);
        return {4'h9, 4'(i), 4'(i + 3), 4'(15 - i)};
    endfunction : fw

    // fuse store answers the cycle after a request and holds until the next one
    always @(posedge core_clk) begin
        if (fuse_rd_en === 1'b1 && ce === 1'b1) begin
            fuse_rd_data <= fw(int'(fuse_rd_addr));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_byte

    task automatic rd_byte(input logic [11:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_byte

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask : wr_rd

    task automatic rd16(input logic [11:0] a, output logic [15:0] d);
        rd_byte(a, d[7:0]);
        rd_byte(a + 12'h001, d[15:8]);
    endtask : rd16

    task automatic wr16(input logic [11:0] a, input logic [15:0] d);
        wr_byte(a, d[7:0]);
        wr_byte(a + 12'h001, d[15:8]);
    endtask : wr16

    task automatic wait_ready();
        for (int n = 0; n < 100 && trim_ready !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk(16'(trim_ready), 16'h0001);
    endtask : wait_ready

    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] v;
        logic [7:0] b;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        // a write during the fuse load must not survive it
        wr_byte(oa[0], 8'hff);
        wait_ready();
        for (int i = 0; i < 6; i++) begin
            rd16(oa[i], v);
            chk(v, fw(i));
            ofs_m[i] = 16'h5a00 + 16'(i) * 16'h2011 + 16'hc000;
            wr16(oa[i], ofs_m[i]);
        end
        for (int i = 0; i < 3; i++) begin
            rd_byte(ga[i], b);
            chk(16'(b), 16'(fw(6 + i) & 16'h00ff));
            chk(16'(gout[i]), 16'(fw(6 + i) & 16'h001f));
        end
        for (int i = 0; i < 6; i++) begin
            rd16(oa[i], v);
            chk(v, ofs_m[i]);
        end
        // update only the trim nibble of the high byte, keeping reserved bits as read
        rd_byte(oa[0] + 12'h001, b);
        wr_byte(oa[0] + 12'h001, {b[7:4], 4'h3});
        ofs_m[0][11:8] = 4'h3;
        rd16(oa[0], v);
        chk(v, ofs_m[0]);
        gain_m = '{8'hff, 8'he0, 8'h15};
        for (int i = 0; i < 3; i++) begin
            wr_byte(ga[i], gain_m[i]);
        end
        for (int i = 0; i < 3; i++) begin
            rd_byte(ga[i], b);
            chk(16'(b), 16'(gain_m[i]));
            chk(16'(gout[i]), 16'(gain_m[i][4:0]));
        end
        // unmapped places: writes vanish, reads give zero
        wr_byte(12'h350, 8'h77);
        rd_byte(12'h350, b);
        chk(16'(b), 16'h0000);
        rd_byte(12'h362, b);
        chk(16'(b), 16'h0000);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            fg_cal_en <= k[2];
            clk_phase90 <= k[1];
            sel_analog_input_b <= k[0];
            repeat (2) @(posedge core_clk);
            #1;
            v = k[2] ? 16'(ofs_m[k[1:0]][11:0]) : 16'h0000;
            chk(16'(core_a_offset), v);
            v = (k[2] && !k[1]) ? 16'(ofs_m[4 + k[0]][11:0]) : 16'h0000;
            chk(16'(core_b_offset), v);
        end
        // with the clock enable low a write is not taken
        @(posedge core_clk);
        ce <= 1'b0;
        wr_byte(ga[0], 8'h00);
        @(posedge core_clk);
        ce <= 1'b1;
        rd_byte(ga[0], b);
        chk(16'(b), 16'(gain_m[0]));
        // back-to-back strobes: the read sees the byte written just before
        for (int i = 0; i < 6; i++) begin
            wr_rd(oa[i], 8'(i) ^ 8'ha5, b);
            chk(16'(b), 16'(8'(i) ^ 8'ha5));
        end
        wr_rd(ga[2], 8'hb6, b);
        chk(16'(b), 16'h00b6);
        chk(16'(gout[2]), 16'h0016);
        // second reset in mid-run reloads the factory values
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        wait_ready();
        rd16(oa[5], v);
        chk(v, fw(5));
        rd_byte(ga[2], b);
        chk(16'(b), 16'(fw(8) & 16'h00ff));
        results();
    end

    initial begin
        #(100 * 20000);
        err_total++;
        results();
    end

endmodule : adc_core_offset_gain_trim_bank_bench

//--- common/trim_bank_consts.svh
// offsets, field positions, reset values and counts of the trim bank
// assumes a byte-wide configuration port with 12-bit addresses
`ifndef TRIM_BANK_CONSTS_SVH
`define TRIM_BANK_CONSTS_SVH

`define ADDR_W 12
`define DATA_W 8
`define OFS_W 16
`define GAIN_W 8
`define NUM_OFS 6
`define NUM_GAIN 3
`define FUSE_ENTRIES 9
`define FUSE_IDX_W 4

`define OFFSET_TRIM_A_PHASE0_IN_A 12'h344
`define OFFSET_TRIM_A_PHASE0_IN_B 12'h346
`define OFFSET_TRIM_A_PHASE90_IN_A 12'h348
`define OFFSET_TRIM_A_PHASE90_IN_B 12'h34a
`define OFFSET_TRIM_B_PHASE0_IN_A 12'h34c
`define OFFSET_TRIM_B_PHASE0_IN_B 12'h34e
`define OFFSET_FINE_GAIN_BANK_ZERO 12'h360
`define OFFSET_FINE_GAIN_BANK_ONE 12'h361
`define OFFSET_FINE_GAIN_BANK_FOUR 12'h364

`define TRIM_FIELD_MSB 11
`define TRIM_FIELD_LSB 0
`define TRIM_RSV_MSB 15
`define TRIM_RSV_LSB 12
`define GAIN_FIELD_MSB 4
`define GAIN_FIELD_LSB 0
`define GAIN_RSV_MSB 7
`define GAIN_RSV_LSB 5

`define OFS_RESET 16'h0000
`define GAIN_RESET 8'h00
`define RDATA_IDLE 8'h00
`define TRIM_ZERO 12'h000

`endif

//--- common/trim_bank_pkg.sv
// types of the offset and gain trim bank
// assumes the constants header is on the include path
`include "trim_bank_consts.svh"

package trim_bank_pkg;

    typedef enum logic [1:0] {
        FUSE_REQ = 2'b00,
        FUSE_CAP = 2'b01,
        RUN = 2'b10
    } load_state_t;

    typedef struct packed {
        logic hit;
        logic is_gain;
        logic [2:0] idx;
        logic hi_byte;
    } decode_t;

    typedef struct packed {
        load_state_t state;
        logic [`FUSE_IDX_W-1:0] load_idx;
        logic [`NUM_OFS-1:0][`OFS_W-1:0] offs;
        logic [`NUM_GAIN-1:0][`GAIN_W-1:0] gain;
        logic [`DATA_W-1:0] rdata;
        logic [`TRIM_FIELD_MSB:0] core_a_off;
        logic [`TRIM_FIELD_MSB:0] core_b_off;
    } bank_state_t;

endpackage : trim_bank_pkg

//--- hdl/adc_core_offset_gain_trim_bank.sv
// offset and fine-gain trim bank of a dual-core converter
// assumes a byte-wide config port, synchronous inputs and a fuse
// store that answers a read request one enabled cycle later
//
// How it works
// - core A, input A, 0 deg trim register
// - core A, input B, 0 deg trim register
// - core A, input A, 90 deg trim register
// - core A, input B, 90 deg trim register
// - core B, input A, 0 deg trim register
// - core B, input B, 0 deg trim register
// - upper four trim bits stored, no function
// - bank 0 fine gain, 5-bit field
// - bank 1 fine gain, 5-bit field
// - bank 4 fine gain register
// - bank 4 gain low five, reserved upper three
// - reset loads all values from fuse store
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "trim_bank_consts.svh"

module adc_core_offset_gain_trim_bank
    import trim_bank_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`DATA_W-1:0] rdata,
    output logic fuse_rd_en,
    output logic [`FUSE_IDX_W-1:0] fuse_rd_addr,
    input wire logic [`OFS_W-1:0] fuse_rd_data,
    input wire logic fg_cal_en,
    input wire logic clk_phase90,
    input wire logic sel_analog_input_b,
    output logic [`TRIM_FIELD_MSB:0] core_a_offset,
    output logic [`TRIM_FIELD_MSB:0] core_b_offset,
    output logic [`GAIN_FIELD_MSB:0] fine_gain_bank_zero,
    output logic [`GAIN_FIELD_MSB:0] fine_gain_bank_one,
    output logic [`GAIN_FIELD_MSB:0] fine_gain_bank_four,
    output logic trim_ready
);

    ////////////////////////////////////////////////////////////////
    // address decode, shared by the write and the read path

    function automatic decode_t decode(input logic [`ADDR_W-1:0] a);
        decode_t d;
        logic [`ADDR_W-1:0] even;
        d = '0;
        even = {a[`ADDR_W-1:1], 1'b0};
        d.hi_byte = a[0];
        case (even)
            `OFFSET_TRIM_A_PHASE0_IN_A: begin
                d.hit = 1'b1;
                d.idx = 3'd0;
            end
            `OFFSET_TRIM_A_PHASE0_IN_B: begin
                d.hit = 1'b1;
                d.idx = 3'd1;
            end
            `OFFSET_TRIM_A_PHASE90_IN_A: begin
                d.hit = 1'b1;
                d.idx = 3'd2;
            end
            `OFFSET_TRIM_A_PHASE90_IN_B: begin
                d.hit = 1'b1;
                d.idx = 3'd3;
            end
            `OFFSET_TRIM_B_PHASE0_IN_A: begin
                d.hit = 1'b1;
                d.idx = 3'd4;
            end
            `OFFSET_TRIM_B_PHASE0_IN_B: begin
                d.hit = 1'b1;
                d.idx = 3'd5;
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        // gain registers are single bytes, so the full address counts
        case (a)
            `OFFSET_FINE_GAIN_BANK_ZERO: begin
                d = '{hit: 1'b1, is_gain: 1'b1, idx: 3'd0, hi_byte: 1'b0};
            end
            `OFFSET_FINE_GAIN_BANK_ONE: begin
                d = '{hit: 1'b1, is_gain: 1'b1, idx: 3'd1, hi_byte: 1'b0};
            end
            `OFFSET_FINE_GAIN_BANK_FOUR: begin
                d = '{hit: 1'b1, is_gain: 1'b1, idx: 3'd2, hi_byte: 1'b0};
            end
            default: begin
            end
        endcase
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////
    // state

    bank_state_t s_q;
    bank_state_t s_d;
    decode_t dec;
    logic run;

    assign dec = decode(addr);
    assign run = (s_q.state == RUN);

    always_comb begin
        s_d = s_q;
        s_d.rdata = `RDATA_IDLE;
        case (s_q.state)
            FUSE_REQ: begin
                s_d.state = FUSE_CAP;
            end
            FUSE_CAP: begin
                // fuse words 0..5 are offsets, 6..8 are gains
                if (s_q.load_idx < 4'(`NUM_OFS)) begin
                    s_d.offs[s_q.load_idx[2:0]] = fuse_rd_data;
                end else begin
                    s_d.gain[3'(s_q.load_idx - 4'(`NUM_OFS))] =
                        fuse_rd_data[`GAIN_W-1:0];
                end
                if (s_q.load_idx == 4'(`FUSE_ENTRIES - 1)) begin
                    s_d.state = RUN;
                end else begin
                    s_d.state = FUSE_REQ;
                    s_d.load_idx = s_q.load_idx + 4'd1;
                end
            end
            RUN: begin
                // all sixteen bits are stored; the top four are kept
                // for software even though they steer nothing
                if (wr && dec.hit && !dec.is_gain) begin
                    if (dec.hi_byte) begin
                        s_d.offs[dec.idx][15:8] = wdata;
                    end else begin
                        s_d.offs[dec.idx][7:0] = wdata;
                    end
                end
                if (wr && dec.hit && dec.is_gain) begin
                    s_d.gain[dec.idx] = wdata;
                end
                if (rd && dec.hit && !dec.is_gain) begin
                    s_d.rdata = dec.hi_byte ? s_q.offs[dec.idx][15:8]
                                            : s_q.offs[dec.idx][7:0];
                end
                if (rd && dec.hit && dec.is_gain) begin
                    s_d.rdata = s_q.gain[dec.idx];
                end
            end
            default: begin
                s_d.state = FUSE_REQ;
            end
        endcase

        // trim steering: only foreground calibration uses these words
        s_d.core_a_off = `TRIM_ZERO;
        s_d.core_b_off = `TRIM_ZERO;
        if (run && fg_cal_en) begin
            case ({clk_phase90, sel_analog_input_b})
                2'b00: s_d.core_a_off = s_q.offs[0][11:0];
                2'b01: s_d.core_a_off = s_q.offs[1][11:0];
                2'b10: s_d.core_a_off = s_q.offs[2][11:0];
                2'b11: s_d.core_a_off = s_q.offs[3][11:0];
                default: s_d.core_a_off = `TRIM_ZERO;
            endcase
            // core B has 0-degree words only; at 90 degrees it gets none
            if (!clk_phase90) begin
                s_d.core_b_off = sel_analog_input_b ? s_q.offs[5][11:0]
                                                    : s_q.offs[4][11:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    assign rdata = s_q.rdata;
    assign fuse_rd_en = (s_q.state == FUSE_REQ);
    assign fuse_rd_addr = s_q.load_idx;
    assign core_a_offset = s_q.core_a_off;
    assign core_b_offset = s_q.core_b_off;
    assign fine_gain_bank_zero = s_q.gain[0][4:0];
    assign fine_gain_bank_one = s_q.gain[1][4:0];
    assign fine_gain_bank_four = s_q.gain[2][4:0];
    assign trim_ready = run;

    ////////////////////////////////////////////////////////////////
    // assertions

    sequence s_wr_at(logic [`ADDR_W-1:0] a);
        ce && run && wr && (addr == a);
    endsequence

    sequence s_rd_at(logic [`ADDR_W-1:0] a);
        ce && run && rd && (addr == a);
    endsequence

    localparam logic [`ADDR_W-1:0] OFS_ADDR [`NUM_OFS] = '{
        `OFFSET_TRIM_A_PHASE0_IN_A, `OFFSET_TRIM_A_PHASE0_IN_B,
        `OFFSET_TRIM_A_PHASE90_IN_A, `OFFSET_TRIM_A_PHASE90_IN_B,
        `OFFSET_TRIM_B_PHASE0_IN_A, `OFFSET_TRIM_B_PHASE0_IN_B
    };

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_OFS; gi++) begin : g_ofs_chk
            // low byte written, read back the next cycle, data checked one cycle later
            property p_ofs_rw;
                @(posedge core_clk) disable iff (srst)
                s_wr_at(OFS_ADDR[gi]) ##1 s_rd_at(OFS_ADDR[gi])
                |=> rdata == $past(wdata, 2);
            endproperty
            a_ofs_rw: assert property (p_ofs_rw)
                else $error("offset trim low byte did not read back");
        end
    endgenerate

    property p_rsv_keep;
        @(posedge core_clk) disable iff (srst)
        s_wr_at(`OFFSET_TRIM_A_PHASE0_IN_A + 12'h001)
        |=> s_q.offs[0][15:12] == $past(wdata[7:4])
            && s_q.offs[0][11:8] == $past(wdata[3:0]);
    endproperty
    a_rsv_keep: assert property (p_rsv_keep)
        else $error("upper trim byte not stored as written");

    property p_gain0;
        @(posedge core_clk) disable iff (srst)
        s_wr_at(`OFFSET_FINE_GAIN_BANK_ZERO)
        |=> fine_gain_bank_zero == $past(wdata[4:0]);
    endproperty
    a_gain0: assert property (p_gain0)
        else $error("bank 0 gain output wrong after write");

    property p_gain1;
        @(posedge core_clk) disable iff (srst)
        s_wr_at(`OFFSET_FINE_GAIN_BANK_ONE)
        |=> fine_gain_bank_one == $past(wdata[4:0]);
    endproperty
    a_gain1: assert property (p_gain1)
        else $error("bank 1 gain output wrong after write");

    property p_gain4;
        @(posedge core_clk) disable iff (srst)
        s_wr_at(`OFFSET_FINE_GAIN_BANK_FOUR)
        |=> fine_gain_bank_four == $past(wdata[4:0]);
    endproperty
    a_gain4: assert property (p_gain4)
        else $error("bank 4 gain output wrong after write");

    property p_gain4_rsv;
        @(posedge core_clk) disable iff (srst)
        s_wr_at(`OFFSET_FINE_GAIN_BANK_FOUR) ##1
        s_rd_at(`OFFSET_FINE_GAIN_BANK_FOUR)
        |=> rdata[7:5] == $past(wdata[7:5], 2);
    endproperty
    a_gain4_rsv: assert property (p_gain4_rsv)
        else $error("bank 4 reserved bits lost");

    property p_core_a_sel;
        @(posedge core_clk) disable iff (srst)
        ce && run && fg_cal_en && clk_phase90 && !sel_analog_input_b
        |=> core_a_offset == $past(s_q.offs[2][11:0]);
    endproperty
    a_core_a_sel: assert property (p_core_a_sel)
        else $error("core A did not take the 90 deg input A trim");

    property p_core_b_sel;
        @(posedge core_clk) disable iff (srst)
        ce && run && fg_cal_en && !clk_phase90 && sel_analog_input_b
        |=> core_b_offset == $past(s_q.offs[5][11:0]);
    endproperty
    a_core_b_sel: assert property (p_core_b_sel)
        else $error("core B did not take the input B trim");

    property p_fuse_load;
        @(posedge core_clk) disable iff (srst)
        ce && (s_q.state == FUSE_CAP) && (s_q.load_idx == 4'd0)
        |=> s_q.offs[0] == $past(fuse_rd_data);
    endproperty
    a_fuse_load: assert property (p_fuse_load)
        else $error("first fuse word not loaded");

    property p_fuse_done;
        @(posedge core_clk) disable iff (srst)
        ce && (s_q.state == FUSE_CAP) && (s_q.load_idx == 4'd8)
        |=> trim_ready && fine_gain_bank_four == $past(fuse_rd_data[4:0]);
    endproperty
    a_fuse_done: assert property (p_fuse_done)
        else $error("fuse load did not finish on the last word");

    // also covers reads refused while the fuse load is still running
    property p_rd_idle;
        @(posedge core_clk) disable iff (srst)
        ce && !(run && rd && dec.hit) |=> rdata == `RDATA_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data present without a mapped read");

    property p_hi_rd;
        @(posedge core_clk) disable iff (srst)
        s_rd_at(`OFFSET_TRIM_B_PHASE0_IN_B + 12'h001)
        |=> rdata == $past(s_q.offs[5][15:8]);
    endproperty
    a_hi_rd: assert property (p_hi_rd)
        else $error("upper trim byte of core B input B read wrong");

    // without foreground calibration no trim word reaches a core
    property p_cal_off;
        @(posedge core_clk) disable iff (srst)
        ce && !fg_cal_en
        |=> core_a_offset == `TRIM_ZERO && core_b_offset == `TRIM_ZERO;
    endproperty
    a_cal_off: assert property (p_cal_off)
        else $error("trim applied while foreground calibration is off");

    // core B owns no 90 deg word, so it must see zero there
    property p_core_b_p90;
        @(posedge core_clk) disable iff (srst)
        ce && clk_phase90 |=> core_b_offset == `TRIM_ZERO;
    endproperty
    a_core_b_p90: assert property (p_core_b_p90)
        else $error("core B took a trim word at 90 deg");

    // the fuse index must hold across request and capture
    property p_fuse_step;
        @(posedge core_clk) disable iff (srst)
        ce && fuse_rd_en |=> !fuse_rd_en && $stable(fuse_rd_addr);
    endproperty
    a_fuse_step: assert property (p_fuse_step)
        else $error("fuse request not followed by its capture");

endmodule : adc_core_offset_gain_trim_bank
